// ---- src/vml_pkg.sv ----
// Purpose: Shared constants for the long-mode switch and field-width block.
// Assumes: Register port with one-cycle read latency, 40 MHz clock.
// Notes:   Offsets are word indices on the plain register port.
package vml_pkg;
    localparam int          ADDR_W          = 4;
    // Register offsets.
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_CMD         = 4'h1;
    localparam logic [3:0]  REG_FLD_SEL     = 4'h2;
    localparam logic [3:0]  REG_WDATA_LO    = 4'h3;
    localparam logic [3:0]  REG_WDATA_HI    = 4'h4;
    localparam logic [3:0]  REG_RDATA_LO    = 4'h5;
    localparam logic [3:0]  REG_RDATA_HI    = 4'h6;
    localparam logic [3:0]  REG_STATUS      = 4'h7;
    localparam logic [3:0]  REG_IMAGE       = 4'h8;
    // Control register fields.
    localparam int          CTL_PG          = 0;
    localparam int          CTL_PAE         = 1;
    localparam int          CTL_HOST_ASZ    = 2;
    localparam int          CTL_GUEST_LM    = 3;
    localparam int          CTL_CALLER_64   = 4;
    localparam int          CTL_IMG_EN      = 5;
    localparam int          CTL_HOST_LMA    = 6;
    localparam int          CTL_SAVED_CSL   = 7;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    // Command codes written to the command register.
    localparam logic [3:0]  CMD_EXIT        = 4'h1;
    localparam logic [3:0]  CMD_ENTRY       = 4'h2;
    localparam logic [3:0]  CMD_FREAD       = 4'h3;
    localparam logic [3:0]  CMD_FWRITE      = 4'h4;
    localparam logic [3:0]  CMD_VINSN       = 4'h5;
    localparam logic [3:0]  CMD_MCALL       = 4'h6;
    // Field selector layout: bit 8 marks natural width, bits 2:1 pick a slot,
    // bit 0 of a fixed 64-bit encoding selects the high half.
    localparam int          SEL_NATURAL     = 8;
    localparam int          SEL_HIGH        = 0;
    localparam int          SEL_SLOT_LO     = 1;
    localparam int          NUM_FIELDS      = 4;
    // Status bits.
    localparam int          ST_LME          = 0;
    localparam int          ST_LMA          = 1;
    localparam int          ST_CSL          = 2;
    localparam int          ST_GUEST        = 3;
    localparam int          ST_SUB64        = 4;
    localparam int          ST_ENTRY_FAIL   = 5;
    localparam int          ST_ABORT        = 6;
    localparam int          ST_GP           = 7;
    localparam int          ST_UD           = 8;
    localparam int          ST_MCALL        = 9;
    localparam int          IMG_LME         = 8;
    typedef enum logic [1:0] {VML_HOST, VML_GUEST, VML_ABORTED} vml_state_t;
endpackage : vml_pkg

// ---- src/vml_mode_calc.sv ----
// Purpose: Derives the long-mode active bit from its three inputs.
// Assumes: Purely combinational, same clock domain as its user.
// Notes:   Any active-bit value carried in a load image never reaches here.
`timescale 1ns/1ps
`default_nettype none
module vml_mode_calc (
    input  wire logic long_mode_enable,
    input  wire logic pg,
    input  wire logic pae,
    output logic      long_mode_active
);
    assign long_mode_active = long_mode_enable & pg & pae;
endmodule : vml_mode_calc
`default_nettype wire

// ---- src/vml_field_store.sv ----
// Purpose: Control-structure field store with caller-width sizing.
// Assumes: One access per cycle, strobes from the mode switch.
// Notes:   Fixed 64-bit fields keep 64 bits from a 64-bit caller; a 32-bit low write zeroes the high half. Natural fields track caller width.
`timescale 1ns/1ps
`default_nettype none
module vml_field_store
    import vml_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [8:0]  sel,
    input  wire logic        caller_64,
    input  wire logic [63:0] wdata,
    output logic [63:0]      rdata_ff
);
    logic [63:0] field_ff [NUM_FIELDS];
    logic [63:0] nxt_field [NUM_FIELDS];
    logic [63:0] nxt_rdata;
    logic [1:0]  slot;
    logic        natural, high;

    assign slot    = sel[SEL_SLOT_LO +: 2];
    assign natural = sel[SEL_NATURAL];
    assign high    = sel[SEL_HIGH] & ~natural;

    always_comb begin
        nxt_field = field_ff;
        nxt_rdata = rdata_ff;
        if (wr) begin
            if (high)
                nxt_field[slot][63:32] = wdata[31:0];
            else if (caller_64)
                nxt_field[slot] = wdata;
            else if (natural)
                nxt_field[slot] = {32'h0000_0000, wdata[31:0]};
            else
                nxt_field[slot] = {32'h0000_0000, wdata[31:0]};
        end
        if (rd) begin
            if (high)
                nxt_rdata = {32'h0000_0000, field_ff[slot][63:32]};
            else if (caller_64)
                nxt_rdata = field_ff[slot];
            else
                nxt_rdata = {32'h0000_0000, field_ff[slot][31:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_FIELDS; i++)
                field_ff[i] <= 64'h0;
            rdata_ff <= 64'h0;
        end else begin
            field_ff <= nxt_field;
            rdata_ff <= nxt_rdata;
        end
    end
endmodule : vml_field_store
`default_nettype wire

// ---- src/vml_mode_switch.sv ----
// Purpose: Long-mode switching on guest exit and entry, field access sizing.
// Assumes: Monitor software drives commands over the plain register port.
// Notes:   Every command completes in the cycle after its write strobe.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module vml_mode_switch
    import vml_pkg::*;
(
    input  wire logic              CLOCK,
    input  wire logic              RST_N,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [31:0]       WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic [31:0]            RDATA,
    output logic                   LONG_MODE_ENABLE,
    output logic                   LONG_MODE_ACTIVE,
    output logic                   CS_LONG,
    output logic                   IN_GUEST,
    output logic                   INVALID_OPCODE,
    output logic                   GP_FAULT
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [8:0]  sel_ff;
    logic [8:0]  nxt_sel;
    logic [31:0] wlo_ff;
    logic [31:0] nxt_wlo;
    logic [31:0] whi_ff;
    logic [31:0] nxt_whi;
    logic [31:0] image_ff;
    logic [31:0] nxt_image;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        lme_ff;
    logic        nxt_lme;
    logic        lma_ff;
    logic        nxt_lma;
    logic        csl_ff;
    logic        nxt_csl;
    logic        sub64_ff;
    logic        nxt_sub64;
    logic        fail_ff;
    logic        nxt_fail;
    logic        abort_ff;
    logic        nxt_abort;
    logic        gp_ff;
    logic        nxt_gp;
    logic        ud_ff;
    logic        nxt_ud;
    logic        mcall_ff;
    logic        nxt_mcall;
    logic        guest_ff;
    logic        nxt_guest;
    vml_state_t  state_ff;
    vml_state_t  nxt_state;

    logic        cmd_wr;
    logic [3:0]  cmd;
    logic        caller_64;
    logic        fld_rd;
    logic        fld_wr;
    logic [63:0] fld_rdata;
    logic [31:0] status;
    logic        entry64_ok;
    logic        exit_img_fault;
    logic        entry_img_fault;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    // Long mode active with a 32-bit code segment is compatibility sub-mode,
    // where the virtualization-instruction command faults, and field accesses fault in the host.
    function automatic logic compat_sub(input logic long_mode_active, input logic csl);
        return long_mode_active & ~csl;
    endfunction : compat_sub

    assign cmd_wr = WR && (ADDR == REG_CMD);
    assign cmd    = WDATA[3:0];

    // The monitor counts as a 64-bit caller only while it really runs in a
    // 64-bit segment; in a guest or a compatibility segment it is 32-bit.
    assign caller_64 = ctrl_ff[CTL_CALLER_64] & csl_ff & lma_ff & (state_ff == VML_HOST);

    // The active bit is always recomputed from the next enable, paging and
    // address-extension values, so an image can never set it directly.
    vml_mode_calc u_calc (
        .long_mode_enable (nxt_lme),
        .pg  (nxt_ctrl[CTL_PG]),
        .pae (nxt_ctrl[CTL_PAE]),
        .long_mode_active (nxt_lma)
    );

    assign nxt_guest = (nxt_state == VML_GUEST);

    // A 64-bit guest needs paging, address extension, an active long-mode
    // host and the host address-size control; a 32-bit guest needs none.
    assign entry64_ok      = ctrl_ff[CTL_PG] & ctrl_ff[CTL_PAE]
                           & lma_ff & ctrl_ff[CTL_HOST_ASZ];
    // An image that would drop the enable bit while paging is on faults.
    assign exit_img_fault  = ctrl_ff[CTL_IMG_EN] & ~image_ff[IMG_LME]
                           & ctrl_ff[CTL_HOST_ASZ] & ctrl_ff[CTL_PG];
    assign entry_img_fault = ctrl_ff[CTL_IMG_EN] & ctrl_ff[CTL_GUEST_LM]
                           & ~image_ff[IMG_LME] & ctrl_ff[CTL_PG];

    vml_field_store u_fields (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .wr        (fld_wr),
        .rd        (fld_rd),
        .sel       (sel_ff),
        .caller_64 (caller_64),
        .wdata     ({whi_ff, wlo_ff}),
        .rdata_ff  (fld_rdata)
    );

    // ----------------------------------------------------------------
    // Command and mode sequencing
    // ----------------------------------------------------------------
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_sel   = sel_ff;
        nxt_wlo   = wlo_ff;
        nxt_whi   = whi_ff;
        nxt_image = image_ff;
        nxt_lme   = lme_ff;
        nxt_csl   = csl_ff;
        nxt_sub64 = sub64_ff;
        nxt_fail  = fail_ff;
        nxt_abort = abort_ff;
        nxt_gp    = 1'b0;
        nxt_ud    = 1'b0;
        nxt_mcall = 1'b0;
        nxt_state = state_ff;
        fld_rd    = 1'b0;
        fld_wr    = 1'b0;
        if (WR) begin
            unique case (ADDR)
                REG_CTRL:     nxt_ctrl  = WDATA;
                REG_FLD_SEL:  nxt_sel   = WDATA[8:0];
                REG_WDATA_LO: nxt_wlo   = WDATA;
                REG_WDATA_HI: nxt_whi   = WDATA;
                REG_IMAGE:    nxt_image = WDATA;
                default:      ;
            endcase
        end
        // After an abort every command is ignored until the next reset.
        if (cmd_wr && state_ff != VML_ABORTED) begin
            unique case (cmd)
                CMD_EXIT: if (state_ff == VML_GUEST) begin
                    nxt_lme   = ctrl_ff[CTL_HOST_ASZ];
                    nxt_csl   = ctrl_ff[CTL_HOST_ASZ];
                    nxt_fail  = 1'b0;
                    nxt_state = VML_HOST;
                    // Mode bits land first; an enabled image then overrides the enable bit unless it faults.
                    // The abort is sticky: software can no longer trust the host state.
                    if (exit_img_fault) begin
                        nxt_gp    = 1'b1;
                        nxt_abort = 1'b1;
                        nxt_state = VML_ABORTED;
                    end else if (ctrl_ff[CTL_IMG_EN]) begin
                        nxt_lme = image_ff[IMG_LME];
                    end
                end
                CMD_ENTRY: if (state_ff == VML_HOST) begin
                    if (ctrl_ff[CTL_GUEST_LM] && !entry64_ok) begin
                        nxt_fail = 1'b1;
                    end else if (entry_img_fault) begin
                        nxt_gp   = 1'b1;
                        nxt_fail = 1'b1;
                    end else begin
                        nxt_fail  = 1'b0;
                        nxt_lme   = ctrl_ff[CTL_GUEST_LM];
                        nxt_csl   = ctrl_ff[CTL_GUEST_LM] & ctrl_ff[CTL_SAVED_CSL];
                        nxt_sub64 = ctrl_ff[CTL_GUEST_LM] & ctrl_ff[CTL_SAVED_CSL];
                        nxt_state = VML_GUEST;
                    end
                end
                CMD_FREAD, CMD_FWRITE: begin
                    // Field accesses use the selector and data latched earlier,
                    // so software must set them up before issuing the command.
                    if (compat_sub(lma_ff, csl_ff) && state_ff == VML_HOST)
                        nxt_ud = 1'b1;
                    else if (cmd == CMD_FREAD)
                        fld_rd = 1'b1;
                    else
                        fld_wr = 1'b1;
                end
                CMD_VINSN: if (compat_sub(lma_ff, csl_ff)) nxt_ud = 1'b1;
                CMD_MCALL: nxt_mcall = 1'b1;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    assign status = {22'h0,
                     mcall_ff,
                     ud_ff,
                     gp_ff,
                     abort_ff,
                     fail_ff,
                     sub64_ff,
                     guest_ff,
                     csl_ff,
                     lma_ff,
                     lme_ff};

    // Read data stand only in the cycle after the strobe and are zero
    // otherwise, so a stale word never looks like a fresh answer.
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (RD) begin
            unique case (ADDR)
                REG_CTRL:     nxt_rdata = ctrl_ff;
                REG_FLD_SEL:  nxt_rdata = {23'h0, sel_ff};
                REG_WDATA_LO: nxt_rdata = wlo_ff;
                REG_WDATA_HI: nxt_rdata = whi_ff;
                REG_RDATA_LO: nxt_rdata = fld_rdata[31:0];
                REG_RDATA_HI: nxt_rdata = fld_rdata[63:32];
                REG_STATUS:   nxt_rdata = status;
                REG_IMAGE:    nxt_rdata = image_ff;
                default:      nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctrl_ff  <= CTRL_RESET;
            sel_ff   <= 9'h000;
            wlo_ff   <= 32'h0;
            whi_ff   <= 32'h0;
            image_ff <= 32'h0;
            rdata_ff <= 32'h0;
            lme_ff   <= 1'b0;
            lma_ff   <= 1'b0;
            guest_ff <= 1'b0;
            csl_ff   <= 1'b0;
            sub64_ff <= 1'b0;
            fail_ff  <= 1'b0;
            abort_ff <= 1'b0;
            gp_ff    <= 1'b0;
            ud_ff    <= 1'b0;
            mcall_ff <= 1'b0;
            state_ff <= VML_HOST;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            sel_ff   <= nxt_sel;
            wlo_ff   <= nxt_wlo;
            whi_ff   <= nxt_whi;
            image_ff <= nxt_image;
            rdata_ff <= nxt_rdata;
            lme_ff   <= nxt_lme;
            lma_ff   <= nxt_lma;
            guest_ff <= nxt_guest;
            csl_ff   <= nxt_csl;
            sub64_ff <= nxt_sub64;
            fail_ff  <= nxt_fail;
            abort_ff <= nxt_abort;
            gp_ff    <= nxt_gp;
            ud_ff    <= nxt_ud;
            mcall_ff <= nxt_mcall;
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign RDATA            = rdata_ff;
    assign LONG_MODE_ENABLE = lme_ff;
    assign LONG_MODE_ACTIVE = lma_ff;
    assign CS_LONG          = csl_ff;
    assign IN_GUEST         = guest_ff;
    assign INVALID_OPCODE   = ud_ff;
    assign GP_FAULT         = gp_ff;
endmodule : vml_mode_switch
`default_nettype wire

// ---- dv/vml_mode_switch_sva.sv ----
// Purpose: Assertions on the ports of the long-mode switch.
// Assumes: Command codes sit in write data bits 3:0.
// Notes:   A shadow of the control register supplies exit and entry inputs.
`timescale 1ns/1ps
`default_nettype none
module vml_mode_switch_sva
    import vml_pkg::*;
(
    input wire logic              CLOCK,
    input wire logic              RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0]       WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [31:0]       RDATA,
    input wire logic              LONG_MODE_ENABLE,
    input wire logic              LONG_MODE_ACTIVE,
    input wire logic              CS_LONG,
    input wire logic              IN_GUEST,
    input wire logic              INVALID_OPCODE,
    input wire logic              GP_FAULT
);
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (!RST_N) begin
            nxt_ctrl = CTRL_RESET;
        end else if (WR && ADDR == REG_CTRL) begin
            nxt_ctrl = WDATA;
        end
    end
    always_ff @(posedge CLOCK) begin
        ctrl_ff <= nxt_ctrl;
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence s_cmd(logic [3:0] code);
        WR && ADDR == REG_CMD && WDATA[3:0] == code;
    endsequence
    sequence s_host_entry;
        s_cmd(CMD_ENTRY) ##0 !IN_GUEST;
    endsequence
    property p_rdata_idle;
        !$past(RD) |-> RDATA == 32'h0;
    endproperty
    property p_lma;
        LONG_MODE_ACTIVE |-> LONG_MODE_ENABLE && ctrl_ff[CTL_PG] && ctrl_ff[CTL_PAE];
    endproperty
    property p_exit;
        s_cmd(CMD_EXIT) ##0 IN_GUEST |=> !IN_GUEST
            && LONG_MODE_ENABLE == $past(ctrl_ff[CTL_HOST_ASZ]) && CS_LONG == $past(ctrl_ff[CTL_HOST_ASZ]);
    endproperty
    property p_entry32;
        s_host_entry ##0 !ctrl_ff[CTL_GUEST_LM] |=> IN_GUEST && !LONG_MODE_ENABLE && !LONG_MODE_ACTIVE;
    endproperty
    property p_entry_fail;
        s_host_entry ##0 ctrl_ff[CTL_GUEST_LM] && !ctrl_ff[CTL_HOST_ASZ] |=> !IN_GUEST;
    endproperty
    property p_entry64;
        s_host_entry ##0 (ctrl_ff[3:0] == 4'hf) && !ctrl_ff[CTL_IMG_EN] && LONG_MODE_ACTIVE
            |=> IN_GUEST && LONG_MODE_ACTIVE && CS_LONG == $past(ctrl_ff[CTL_SAVED_CSL]);
    endproperty
    property p_ud;
        s_cmd(CMD_VINSN) ##0 LONG_MODE_ACTIVE && !CS_LONG |=> INVALID_OPCODE;
    endproperty
    property p_reset;
        disable iff (1'b0)
        !RST_N |=> !LONG_MODE_ENABLE && !LONG_MODE_ACTIVE && !CS_LONG && !IN_GUEST && !GP_FAULT;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    a_lma:        assert property (p_lma) else $error("active bit not derived");
    a_exit:       assert property (p_exit) else $error("exit mode bits wrong");
    a_entry32:    assert property (p_entry32) else $error("32-bit entry wrong");
    a_entry_fail: assert property (p_entry_fail) else $error("bad entry accepted");
    a_entry64:    assert property (p_entry64) else $error("64-bit entry wrong");
    a_ud:         assert property (p_ud) else $error("no invalid opcode");
    a_reset:      assert property (p_reset) else $error("outputs not cleared by reset");
endmodule : vml_mode_switch_sva
`default_nettype wire

// ---- dv/vml_monitor.sv ----
// Purpose: Monitor software model that drives the register port.
// Assumes: Strobes change just after a rising edge, one cycle long.
// Notes:   Released lines carry the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module vml_monitor
    import vml_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              in_guest,
    input  wire logic [31:0]       rdata,
    output var logic [ADDR_W-1:0]  addr,
    output var logic [31:0]        wdata,
    output var logic               wr,
    output var logic               rd
);
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Tasks start just after an edge, so strobes follow each other with no gap.
    task automatic w(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask : w
    task automatic r(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : r
    // Shared fields are only written once the guest has left.
    task automatic fwr(input logic [8:0] sel, input logic [63:0] d);
        wait (!in_guest);
        w(REG_FLD_SEL, {23'h0, sel});
        w(REG_WDATA_LO, d[31:0]);
        w(REG_WDATA_HI, d[63:32]);
        w(REG_CMD, {28'h0, CMD_FWRITE});
    endtask : fwr
    task automatic frd(input logic [8:0] sel, output logic [63:0] d);
        w(REG_FLD_SEL, {23'h0, sel});
        w(REG_CMD, {28'h0, CMD_FREAD});
        r(REG_RDATA_LO, d[31:0]);
        r(REG_RDATA_HI, d[63:32]);
    endtask : frd
endmodule : vml_monitor
`default_nettype wire

// ---- dv/vml_mode_switch_bench.sv ----
// Purpose: Self-checking bench for the long-mode switch.
// Assumes: Monitor model issues every bus cycle.
// Notes:   Row outputs are {enable, active, long bit, guest}.
`timescale 1ns/1ps
`default_nettype none
module vml_mode_switch_bench
    import vml_pkg::*;
;
    logic CLOCK;
    logic RST_N;
    logic [ADDR_W-1:0] ADDR;
    logic [31:0] WDATA, RDATA, sts;
    logic WR, RD, LONG_MODE_ENABLE, LONG_MODE_ACTIVE, CS_LONG, IN_GUEST, INVALID_OPCODE, GP_FAULT;
    logic [3:0] mode;
    logic [63:0] all_o, fd;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    typedef struct {logic [31:0] ctrl; logic [3:0] cmd; logic [3:0] exp;} vml_row_t;
    vml_row_t rows [6] = '{
        '{32'h03, CMD_ENTRY, 4'h1},
        '{32'h07, CMD_EXIT, 4'he},
        '{32'h8f, CMD_ENTRY, 4'hf},
        '{32'h07, CMD_EXIT, 4'he},
        '{32'h0b, CMD_ENTRY, 4'he},
        '{32'h0f, CMD_ENTRY, 4'hd}};
    assign mode = {LONG_MODE_ENABLE, LONG_MODE_ACTIVE, CS_LONG, IN_GUEST};
    assign all_o = {RDATA, 26'h0, INVALID_OPCODE, GP_FAULT, mode};
    vml_mode_switch vml_mode_switch_i (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .LONG_MODE_ENABLE(LONG_MODE_ENABLE),
        .LONG_MODE_ACTIVE(LONG_MODE_ACTIVE), .CS_LONG(CS_LONG), .IN_GUEST(IN_GUEST),
        .INVALID_OPCODE(INVALID_OPCODE), .GP_FAULT(GP_FAULT));
    vml_monitor vml_monitor_i (.clk(CLOCK), .in_guest(IN_GUEST), .rdata(RDATA), .addr(ADDR),
        .wdata(WDATA), .wr(WR), .rd(RD));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        RST_N = 1'b0;
        repeat (20) @(posedge CLOCK);
        RST_N <= 1'b1;
        #1;
        chk(all_o, 64'h0);
        foreach (rows[i]) begin
            vml_monitor_i.w(REG_CTRL, rows[i].ctrl);
            vml_monitor_i.w(REG_CMD, {28'h0, rows[i].cmd});
            chk({60'h0, mode}, {60'h0, rows[i].exp});
        end
        vml_monitor_i.w(REG_CMD, {28'h0, CMD_VINSN});
        chk(64'(INVALID_OPCODE), 64'h1);
        vml_monitor_i.w(REG_CMD, {28'h0, CMD_MCALL});
        chk(64'(INVALID_OPCODE), 64'h0);
        vml_monitor_i.r(REG_STATUS, sts);
        chk(64'(sts[ST_MCALL]), 64'h1);
        vml_monitor_i.w(REG_CTRL, 32'h17);
        vml_monitor_i.w(REG_CMD, {28'h0, CMD_EXIT});
        vml_monitor_i.fwr(9'h002, 64'h1122334455667788);
        vml_monitor_i.frd(9'h002, fd);
        chk(fd, 64'h1122334455667788);
        vml_monitor_i.fwr(9'h100, 64'h0123456789abcdef);
        vml_monitor_i.frd(9'h100, fd);
        chk(fd, 64'h0123456789abcdef);
        vml_monitor_i.w(REG_CTRL, 32'h07);
        vml_monitor_i.frd(9'h002, fd);
        chk(fd, 64'h55667788);
        vml_monitor_i.frd(9'h003, fd);
        chk(fd, 64'h11223344);
        vml_monitor_i.frd(9'h100, fd);
        chk(fd, 64'h89abcdef);
        vml_monitor_i.fwr(9'h002, 64'haaaa000099887766);
        vml_monitor_i.w(REG_CTRL, 32'h17);
        vml_monitor_i.frd(9'h002, fd);
        chk(fd, 64'h99887766);
        vml_monitor_i.w(REG_IMAGE, 32'h0);
        vml_monitor_i.w(REG_CTRL, 32'h2f);
        vml_monitor_i.w(REG_CMD, {28'h0, CMD_ENTRY});
        chk({62'h0, GP_FAULT, IN_GUEST}, 64'h2);
        vml_monitor_i.r(REG_STATUS, sts);
        chk(64'(sts[ST_ENTRY_FAIL]), 64'h1);
        vml_monitor_i.w(REG_CTRL, 32'h8f);
        vml_monitor_i.w(REG_CMD, {28'h0, CMD_ENTRY});
        vml_monitor_i.w(REG_CTRL, 32'haf);
        vml_monitor_i.w(REG_CMD, {28'h0, CMD_EXIT});
        chk({61'h0, GP_FAULT, LONG_MODE_ENABLE, IN_GUEST}, 64'h6);
        vml_monitor_i.w(REG_CMD, {28'h0, CMD_ENTRY});
        vml_monitor_i.r(REG_STATUS, sts);
        chk({62'h0, sts[ST_ABORT], sts[ST_GUEST]}, 64'h2);
        @(posedge CLOCK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RST_N <= 1'b1;
        #1;
        chk(all_o, 64'h0);
        vml_monitor_i.r(REG_STATUS, sts);
        chk({32'h0, sts}, 64'h0);
        end_sim();
    end
endmodule : vml_mode_switch_bench
bind vml_mode_switch vml_mode_switch_sva vml_mode_switch_sva_i (.CLOCK(CLOCK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .LONG_MODE_ENABLE(LONG_MODE_ENABLE), .LONG_MODE_ACTIVE(LONG_MODE_ACTIVE), .CS_LONG(CS_LONG),
    .IN_GUEST(IN_GUEST), .INVALID_OPCODE(INVALID_OPCODE), .GP_FAULT(GP_FAULT));
`default_nettype wire
